// >>> shared/fsw_pkg.sv
/*
 * fsw_pkg: register map, command codes, watchdog states and timing constants
 * of the fieldbus slave watchdog and its vendor register map.
 * Assumes a 100 MHz system clock and a request decoder that delivers one
 * word access per cycle at a 16-bit register address.
 */
// Summary of operation
// [RULE1] every valid request restarts the running count
// [RULE2] setup bits choose state-read and explicit triggers
// [RULE3] missing trigger within timeout raises timeout response
// [RULE4] setup bit lets timeout close all connections
// [RULE5] setup bit 7 selects manual or auto-armed
// [RULE6] auto-armed runs whenever timeout is nonzero
// [RULE7] auto-armed accepts only start, as trigger
// [RULE8] auto-armed stops only by leaving that mode
// [RULE9] led flash code as three read-only words
// [RULE10] run state word: 1 stopped, 2 running
// [RULE11] total input word count constant 0x7d00
// [RULE12] analog input word count constant 0x7d00
// [RULE13] digital input word count constant 0x8000
// [RULE14] analog output word count constant 0x7d00
// [RULE15] digital output word count constant 0x8000
// [RULE16] process image layout version read-only word
// [RULE17] read-write word for connection guard setting
// [RULE18] timeout in 1 ms steps, zero unconfigured
// [RULE19] decode start, stop, reset; else data exception
// [RULE20] state reads ffff, 0000, 0001, 0002
// [RULE21] timeout writes refused while running or expired
// [RULE22] one millisecond tick from system clock
`default_nettype none
package fsw_pkg;
	localparam logic [15:0] ADR_COMMAND     = 16'hfa00;
	localparam logic [15:0] ADR_TIMEOUT     = 16'hfa01;
	localparam logic [15:0] ADR_STATE       = 16'hfa02;
	localparam logic [15:0] ADR_SETUP       = 16'hfa03;
	localparam logic [15:0] ADR_TCP_GUARD   = 16'hfa04;
	localparam logic [15:0] ADR_LED_ONE     = 16'hfa0a;
	localparam logic [15:0] ADR_LED_TWO     = 16'hfa0b;
	localparam logic [15:0] ADR_LED_THREE   = 16'hfa0c;
	localparam logic [15:0] ADR_RUN_STATE   = 16'hfa0d;
	localparam logic [15:0] ADR_ORDER       = 16'hfa10;
	localparam logic [15:0] ADR_FW_STATE    = 16'hfa14;
	localparam logic [15:0] ADR_HW_REV      = 16'hfa15;
	localparam logic [15:0] ADR_LOADER_REV  = 16'hfa16;
	localparam logic [15:0] ADR_IMAGE_VER   = 16'hfa17;
	localparam logic [15:0] ADR_HW_ADDR     = 16'hfa20;
	localparam logic [15:0] ADR_IN_TOTAL    = 16'hfa40;
	localparam logic [15:0] ADR_IN_ANALOG   = 16'hfa41;
	localparam logic [15:0] ADR_IN_DIGITAL  = 16'hfa42;
	localparam logic [15:0] ADR_OUT_TOTAL   = 16'hfa43;
	localparam logic [15:0] ADR_OUT_ANALOG  = 16'hfa44;
	localparam logic [15:0] ADR_OUT_DIGITAL = 16'hfa45;
	localparam logic [15:0] ADR_PATTERN_A   = 16'hfaa0;
	localparam logic [15:0] ADR_PATTERN_B   = 16'hfaa1;
	localparam logic [15:0] ADR_PATTERN_C   = 16'hfaa2;
	localparam logic [15:0] ADR_HEARTBEAT   = 16'hfafa;

	// constant register contents
	localparam logic [15:0] VAL_IN_TOTAL    = 16'h7d00;
	localparam logic [15:0] VAL_IN_ANALOG   = 16'h7d00;
	localparam logic [15:0] VAL_IN_DIGITAL  = 16'h8000;
	localparam logic [15:0] VAL_OUT_TOTAL   = 16'h7d00;
	localparam logic [15:0] VAL_OUT_ANALOG  = 16'h7d00;
	localparam logic [15:0] VAL_OUT_DIGITAL = 16'h8000;
	localparam logic [15:0] VAL_PATTERN_A   = 16'h1234;
	localparam logic [15:0] VAL_PATTERN_B   = 16'haaaa;
	localparam logic [15:0] VAL_PATTERN_C   = 16'h5555;
	localparam logic [15:0] VAL_IMAGE_VER   = 16'h0001;
	localparam logic [15:0] VAL_RUN_STOP    = 16'h0001;
	localparam logic [15:0] VAL_RUN_RUN     = 16'h0002;

	// command codes
	localparam logic [15:0] CMD_START = 16'h5555;
	localparam logic [15:0] CMD_STOP  = 16'h55aa;
	localparam logic [15:0] CMD_RESET = 16'haaaa;

	// state register read values
	localparam logic [15:0] ST_NO_TIMEOUT = 16'hffff;
	localparam logic [15:0] ST_STOPPED    = 16'h0000;
	localparam logic [15:0] ST_RUNNING    = 16'h0001;
	localparam logic [15:0] ST_EXPIRED    = 16'h0002;

	// exception codes
	localparam logic [7:0] EXC_NONE       = 8'h00;
	localparam logic [7:0] EXC_ILLEGAL_FN = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_DV = 8'h03;

	// setup register bit positions
	localparam int SETUP_EXPLICIT_BIT = 0;
	localparam int SETUP_STATE_TRIG   = 1;
	localparam int SETUP_CLOSE_TCP    = 2;
	localparam int SETUP_AUTO_BIT     = 7;
	localparam logic [15:0] SETUP_RESET   = 16'h0000;
	localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
	localparam logic [15:0] GUARD_RESET   = 16'h0000;

	// timing: one millisecond at the system clock rate
	localparam int CLK_HZ        = 100_000_000;
	localparam int TICK_MS       = 1;
	localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
	localparam int CLOSE_PULSE   = 1;

	typedef enum logic [1:0] {
		FSW_NO_TIMEOUT = 2'b00,
		FSW_STOPPED    = 2'b01,
		FSW_RUNNING    = 2'b11,
		FSW_EXPIRED    = 2'b10
	} fsw_state_t;
endpackage : fsw_pkg
`default_nettype wire

// >>> rtl/fsw_watchdog.sv
/*
 * fsw_watchdog: communication watchdog and vendor register map of a fieldbus
 * slave. Register accesses arrive as single-cycle word strobes from the
 * protocol engine; every access is answered one cycle later with read data
 * and an exception code. Valid requests on other registers arrive on
 * req_valid. Status words (led code, run state, identity) are inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module fsw_watchdog #(
	parameter int TICK_DIV = fsw_pkg::TICK_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        reg_rd,
	input  wire logic        reg_wr,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        req_valid,
	input  wire logic [15:0] led_code_one,
	input  wire logic [15:0] led_code_two,
	input  wire logic [15:0] led_code_three,
	input  wire logic        ctrl_running,
	input  wire logic [63:0] order_code,
	input  wire logic [15:0] fw_state,
	input  wire logic [15:0] hw_revision,
	input  wire logic [15:0] loader_revision,
	input  wire logic [47:0] hw_address,
	output logic             ack_r,
	output logic      [15:0] rdata_r,
	output logic       [7:0] exc_r,
	output logic             expired_r,
	output logic             close_tcp_r,
	output logic             running_r
);
	fsw_pkg::fsw_state_t state_r;
	fsw_pkg::fsw_state_t state_nxt;
	logic [15:0] timeout_r;
	logic [15:0] setup_r;
	logic [15:0] guard_r;
	logic [15:0] count_r;
	logic [15:0] heartbeat_r;
	logic [31:0] div_r;
	logic        tick;
	logic        auto_mode;
	logic        explicit_mode;
	logic        trigger;
	logic        cmd_wr;
	logic        to_wr;
	logic        setup_wr;
	logic        to_wr_ok;
	logic        setup_wr_ok;
	logic        cmd_ok;
	logic [7:0]  exc_nxt;
	logic [15:0] rd_mux;

	// word select within a multi-word identity register
	function automatic logic [15:0] word_of(input logic [63:0] v, input logic [1:0] i);
		word_of = v[16*i +: 16];
	endfunction : word_of

	assign auto_mode     = setup_r[fsw_pkg::SETUP_AUTO_BIT];    // RULE5
	assign explicit_mode = setup_r[fsw_pkg::SETUP_EXPLICIT_BIT];
	assign cmd_wr        = reg_wr && (reg_addr == fsw_pkg::ADR_COMMAND);
	assign to_wr         = reg_wr && (reg_addr == fsw_pkg::ADR_TIMEOUT);
	assign setup_wr      = reg_wr && (reg_addr == fsw_pkg::ADR_SETUP);

	// timeout writable only when not running or expired
	assign to_wr_ok = (state_r == fsw_pkg::FSW_NO_TIMEOUT)
		|| (state_r == fsw_pkg::FSW_STOPPED);                   // RULE21
	// setup writable always in auto mode, else only when idle
	assign setup_wr_ok = auto_mode || to_wr_ok;

	// command legality by state and mode
	always_comb begin
		cmd_ok = 1'b0;
		unique case (reg_wdata)
			fsw_pkg::CMD_START: cmd_ok = (state_r != fsw_pkg::FSW_NO_TIMEOUT)
				&& (auto_mode || state_r != fsw_pkg::FSW_EXPIRED); // RULE7
			fsw_pkg::CMD_STOP:  cmd_ok = !auto_mode
				&& (state_r == fsw_pkg::FSW_STOPPED || state_r == fsw_pkg::FSW_RUNNING);
			fsw_pkg::CMD_RESET: cmd_ok = !auto_mode
				&& (state_r == fsw_pkg::FSW_EXPIRED);
			default:            cmd_ok = 1'b0;                     // RULE19
		endcase
	end

	// trigger: any valid request, state read per setup, explicit start
	always_comb begin
		trigger = 1'b0;
		if (!explicit_mode && req_valid)
			trigger = 1'b1;                                        // RULE1
		// only accesses answered without exception count; refused ones are no request
		if (!explicit_mode && (reg_rd || reg_wr) && exc_nxt == fsw_pkg::EXC_NONE
			&& !(reg_rd && reg_addr == fsw_pkg::ADR_STATE))
			trigger = 1'b1;                                        // RULE1
		if (!explicit_mode && reg_rd && (reg_addr == fsw_pkg::ADR_STATE)
			&& setup_r[fsw_pkg::SETUP_STATE_TRIG])
			trigger = 1'b1;                                        // RULE2
		if (cmd_wr && cmd_ok && reg_wdata == fsw_pkg::CMD_START)
			trigger = 1'b1;                                        // RULE7
	end

	// millisecond tick divider
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_r <= 32'h0000_0000;
		end else if (div_r == 32'(TICK_DIV - 1)) begin
			div_r <= 32'h0000_0000;
		end else begin
			div_r <= div_r + 32'h0000_0001;
		end
	end
	assign tick = (div_r == 32'(TICK_DIV - 1));                  // RULE22

	// state transitions
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			fsw_pkg::FSW_NO_TIMEOUT: begin
				if (to_wr && reg_wdata != 16'h0000)
					state_nxt = auto_mode ? fsw_pkg::FSW_RUNNING : fsw_pkg::FSW_STOPPED; // RULE6
			end
			fsw_pkg::FSW_STOPPED: begin
				if (to_wr && reg_wdata == 16'h0000)
					state_nxt = fsw_pkg::FSW_NO_TIMEOUT;           // RULE18
				else if (auto_mode)
					state_nxt = fsw_pkg::FSW_RUNNING;              // RULE6
				else if (cmd_wr && cmd_ok && reg_wdata == fsw_pkg::CMD_START)
					state_nxt = fsw_pkg::FSW_RUNNING;
			end
			fsw_pkg::FSW_RUNNING: begin
				if (!auto_mode && cmd_wr && cmd_ok && reg_wdata == fsw_pkg::CMD_STOP)
					state_nxt = fsw_pkg::FSW_STOPPED;
				else if (trigger)
					state_nxt = fsw_pkg::FSW_RUNNING;
				else if (tick && count_r <= 16'h0001)
					state_nxt = fsw_pkg::FSW_EXPIRED;              // RULE3
			end
			fsw_pkg::FSW_EXPIRED: begin
				if (auto_mode && trigger)
					state_nxt = fsw_pkg::FSW_RUNNING;
				else if (!auto_mode && cmd_wr && cmd_ok && reg_wdata == fsw_pkg::CMD_RESET)
					state_nxt = fsw_pkg::FSW_STOPPED;
			end
		endcase
		// leaving auto mode deactivates the watchdog
		if (setup_wr && setup_wr_ok && auto_mode && !reg_wdata[fsw_pkg::SETUP_AUTO_BIT]
			&& state_r != fsw_pkg::FSW_NO_TIMEOUT)
			state_nxt = fsw_pkg::FSW_STOPPED;                      // RULE8
	end

	// watchdog state
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= fsw_pkg::FSW_NO_TIMEOUT;
		end else begin
			state_r <= state_nxt;
		end
	end

	// millisecond countdown, reloaded by triggers and on start
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_r <= fsw_pkg::TIMEOUT_RESET;
		end else if (state_nxt == fsw_pkg::FSW_RUNNING
			&& (state_r != fsw_pkg::FSW_RUNNING || trigger)) begin
			count_r <= (state_r == fsw_pkg::FSW_NO_TIMEOUT) ? reg_wdata : timeout_r; // RULE1
		end else if (state_r == fsw_pkg::FSW_RUNNING && tick && count_r != 16'h0000) begin
			count_r <= count_r - 16'h0001;                         // RULE18
		end
	end

	// writable configuration words
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			timeout_r <= fsw_pkg::TIMEOUT_RESET;
			setup_r   <= fsw_pkg::SETUP_RESET;
			guard_r   <= fsw_pkg::GUARD_RESET;
		end else begin
			if (to_wr && to_wr_ok)
				timeout_r <= reg_wdata;                            // RULE21
			if (setup_wr && setup_wr_ok)
				setup_r <= reg_wdata;                              // RULE2
			if (reg_wr && reg_addr == fsw_pkg::ADR_TCP_GUARD)
				guard_r <= reg_wdata;                              // RULE17
		end
	end

	// exception code for the current access
	always_comb begin
		exc_nxt = fsw_pkg::EXC_NONE;
		if (cmd_wr && !cmd_ok)
			exc_nxt = fsw_pkg::EXC_ILLEGAL_DV;                     // RULE19
		else if (to_wr && !to_wr_ok)
			exc_nxt = fsw_pkg::EXC_ILLEGAL_FN;                     // RULE21
		else if (setup_wr && !setup_wr_ok)
			exc_nxt = fsw_pkg::EXC_ILLEGAL_FN;
		else if (reg_rd && reg_addr == fsw_pkg::ADR_COMMAND)
			exc_nxt = fsw_pkg::EXC_ILLEGAL_FN;
	end

	// read multiplexer over the whole map
	always_comb begin
		rd_mux = 16'h0000;
		unique case (reg_addr)
			fsw_pkg::ADR_TIMEOUT:     rd_mux = timeout_r;
			fsw_pkg::ADR_STATE: begin
				unique case (state_r)
					fsw_pkg::FSW_NO_TIMEOUT: rd_mux = fsw_pkg::ST_NO_TIMEOUT; // RULE20
					fsw_pkg::FSW_STOPPED:    rd_mux = fsw_pkg::ST_STOPPED;
					fsw_pkg::FSW_RUNNING:    rd_mux = fsw_pkg::ST_RUNNING;
					fsw_pkg::FSW_EXPIRED:    rd_mux = fsw_pkg::ST_EXPIRED;
				endcase
			end
			fsw_pkg::ADR_SETUP:       rd_mux = setup_r;
			fsw_pkg::ADR_TCP_GUARD:   rd_mux = guard_r;                // RULE17
			fsw_pkg::ADR_LED_ONE:     rd_mux = led_code_one;           // RULE9
			fsw_pkg::ADR_LED_TWO:     rd_mux = led_code_two;           // RULE9
			fsw_pkg::ADR_LED_THREE:   rd_mux = led_code_three;         // RULE9
			fsw_pkg::ADR_RUN_STATE:   rd_mux = ctrl_running ? fsw_pkg::VAL_RUN_RUN
				: fsw_pkg::VAL_RUN_STOP;                               // RULE10
			fsw_pkg::ADR_ORDER:       rd_mux = word_of(order_code, 2'd3);
			16'hfa11:                 rd_mux = word_of(order_code, 2'd2);
			16'hfa12:                 rd_mux = word_of(order_code, 2'd1);
			16'hfa13:                 rd_mux = word_of(order_code, 2'd0);
			fsw_pkg::ADR_FW_STATE:    rd_mux = fw_state;
			fsw_pkg::ADR_HW_REV:      rd_mux = hw_revision;
			fsw_pkg::ADR_LOADER_REV:  rd_mux = loader_revision;
			fsw_pkg::ADR_IMAGE_VER:   rd_mux = fsw_pkg::VAL_IMAGE_VER; // RULE16
			fsw_pkg::ADR_HW_ADDR:     rd_mux = word_of({16'h0000, hw_address}, 2'd2);
			16'hfa21:                 rd_mux = word_of({16'h0000, hw_address}, 2'd1);
			16'hfa22:                 rd_mux = word_of({16'h0000, hw_address}, 2'd0);
			fsw_pkg::ADR_IN_TOTAL:    rd_mux = fsw_pkg::VAL_IN_TOTAL;    // RULE11
			fsw_pkg::ADR_IN_ANALOG:   rd_mux = fsw_pkg::VAL_IN_ANALOG;   // RULE12
			fsw_pkg::ADR_IN_DIGITAL:  rd_mux = fsw_pkg::VAL_IN_DIGITAL;  // RULE13
			fsw_pkg::ADR_OUT_TOTAL:   rd_mux = fsw_pkg::VAL_OUT_TOTAL;
			fsw_pkg::ADR_OUT_ANALOG:  rd_mux = fsw_pkg::VAL_OUT_ANALOG;  // RULE14
			fsw_pkg::ADR_OUT_DIGITAL: rd_mux = fsw_pkg::VAL_OUT_DIGITAL; // RULE15
			fsw_pkg::ADR_PATTERN_A:   rd_mux = fsw_pkg::VAL_PATTERN_A;
			fsw_pkg::ADR_PATTERN_B:   rd_mux = fsw_pkg::VAL_PATTERN_B;
			fsw_pkg::ADR_PATTERN_C:   rd_mux = fsw_pkg::VAL_PATTERN_C;
			fsw_pkg::ADR_HEARTBEAT:   rd_mux = heartbeat_r;
			default:                  rd_mux = 16'h0000;
		endcase
	end

	// access answer, registered one cycle after the strobe
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_r   <= 1'b0;
			rdata_r <= 16'h0000;
			exc_r   <= fsw_pkg::EXC_NONE;
		end else begin
			ack_r   <= reg_rd || reg_wr;
			rdata_r <= (reg_rd && exc_nxt == fsw_pkg::EXC_NONE) ? rd_mux : 16'h0000;
			exc_r   <= exc_nxt;
		end
	end

	// heartbeat word counts milliseconds
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			heartbeat_r <= 16'h0000;
		end else if (tick) begin
			heartbeat_r <= heartbeat_r + 16'h0001;
		end
	end

	// timeout response: expiry level and one-cycle close request
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			expired_r   <= 1'b0;
			close_tcp_r <= 1'b0;
			running_r   <= 1'b0;
		end else begin
			expired_r   <= (state_nxt == fsw_pkg::FSW_EXPIRED);     // RULE3
			close_tcp_r <= (state_nxt == fsw_pkg::FSW_EXPIRED)
				&& (state_r != fsw_pkg::FSW_EXPIRED)
				&& setup_r[fsw_pkg::SETUP_CLOSE_TCP];              // RULE4
			running_r   <= (state_nxt == fsw_pkg::FSW_RUNNING);
		end
	end
endmodule : fsw_watchdog
`default_nettype wire

// >>> sim/fsw_watchdog_props.sv
/* fsw_watchdog_props: port-level assertions for the watchdog register map.
   assumes it is bound to fsw_watchdog, one clock, async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module fsw_watchdog_props (
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic        reg_rd,
	input wire logic        reg_wr,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        ctrl_running,
	input wire logic        ack_r,
	input wire logic [15:0] rdata_r,
	input wire logic  [7:0] exc_r,
	input wire logic        expired_r,
	input wire logic        close_tcp_r,
	input wire logic        running_r
);
	// all checks on the system clock, quiet in reset
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	chk_ack_timing: assert property (ack_r == $past(reg_rd || reg_wr))
		else $error("ack not one cycle after strobe");
	chk_cmd_unreadable: assert property (reg_rd && reg_addr == 16'hfa00 |=> exc_r == 8'h01)
		else $error("command read not refused");
	chk_run_word: assert property (reg_rd && reg_addr == 16'hfa0d
		|=> rdata_r == ($past(ctrl_running) ? 16'h0002 : 16'h0001)) else $error("run word wrong");
	chk_timeout_locked: assert property (reg_wr && reg_addr == 16'hfa01
		&& (running_r || expired_r) |=> exc_r == 8'h01) else $error("timeout write taken");
	chk_state_running: assert property (reg_rd && reg_addr == 16'hfa02 && running_r
		|=> rdata_r == 16'h0001) else $error("state read not running");
	chk_bad_command: assert property (reg_wr && reg_addr == 16'hfa00
		&& !(reg_wdata inside {16'h5555, 16'h55aa, 16'haaaa}) |=> exc_r == 8'h03)
		else $error("bad command accepted");
	chk_close_entry: assert property (close_tcp_r |-> $rose(expired_r))
		else $error("close pulse outside expiry entry");
	chk_expiry_cause: assert property ($rose(expired_r) |-> $past(running_r))
		else $error("expiry without running");
	chk_one_state: assert property (!(running_r && expired_r))
		else $error("running and expired together");
	chk_const_word: assert property (reg_rd && reg_addr == 16'hfa42 |=> rdata_r == 16'h8000)
		else $error("digital input count wrong");
endmodule : fsw_watchdog_props
`default_nettype wire

// >>> sim/fsw_master.sv
/* fsw_master: fieldbus master model, issues word accesses and triggers.
   assumes the slave answers one cycle after the strobe edge. */
`timescale 1ns/1ps
`default_nettype none
module fsw_master (
	input  wire logic        ref_clk,
	input  wire logic        ack_r,
	input  wire logic [15:0] rdata_r,
	input  wire logic  [7:0] exc_r,
	output logic             reg_rd,
	output logic             reg_wr,
	output logic      [15:0] reg_addr,
	output logic      [15:0] reg_wdata,
	output logic             req_valid
);
	// idle bus at time zero
	initial begin
		{reg_rd, reg_wr, req_valid, reg_addr, reg_wdata} = '0;
	end
	// one word access, answer taken 1 ns after the edge that raises ack
	task automatic access(input bit wr, input logic [15:0] a, d, output logic [23:0] ans);
		@(posedge ref_clk) #1;
		reg_rd = !wr;
		reg_wr = wr;
		reg_addr = a;
		reg_wdata = d;
		@(posedge ref_clk) #1;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_addr = ~a; // released bus shows no stale value
		reg_wdata = ~d;
		// answer stands for the whole cycle after the strobe edge
		ans = (ack_r === 1'b1) ? {rdata_r, exc_r} : 24'hxx_xxxx;
		@(posedge ref_clk);
	endtask : access
	// one valid request on another register, a trigger
	task automatic trigger();
		@(posedge ref_clk) #1;
		req_valid = 1'b1;
		@(posedge ref_clk) #1;
		req_valid = 1'b0;
	endtask : trigger
endmodule : fsw_master
`default_nettype wire

// >>> sim/fsw_watchdog_test.sv
/* fsw_watchdog_test: self-checking bench against a behavioural map model.
   assumes fsw_master and fsw_watchdog_props from sim/, tick of 10 cycles. */
`timescale 1ns/1ps
`default_nettype none
module fsw_watchdog_test;
	localparam int TICK_DIV = 10;
	logic        ref_clk, arst_n, ctrl_running, ack_r, expired_r, close_tcp_r, running_r;
	logic        reg_rd, reg_wr, req_valid;
	logic [15:0] reg_addr, reg_wdata, rdata_r, led1, led2, led3, fw_st, hw_rev, ld_rev;
	logic  [7:0] exc_r;
	logic [63:0] order;
	logic [47:0] hw_adr;
	int          num_errors, compares, cycles, closes, st, tmo, setup, guard;
	logic [15:0] cmds [4] = '{16'h5555, 16'h55aa, 16'haaaa, 16'h1234};

	fsw_master i_master (.ref_clk(ref_clk), .ack_r(ack_r), .rdata_r(rdata_r), .exc_r(exc_r),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.req_valid(req_valid));
	fsw_watchdog #(.TICK_DIV(TICK_DIV)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.req_valid(req_valid), .led_code_one(led1), .led_code_two(led2), .led_code_three(led3),
		.ctrl_running(ctrl_running), .order_code(order), .fw_state(fw_st),
		.hw_revision(hw_rev), .loader_revision(ld_rev), .hw_address(hw_adr), .ack_r(ack_r),
		.rdata_r(rdata_r), .exc_r(exc_r), .expired_r(expired_r), .close_tcp_r(close_tcp_r),
		.running_r(running_r));

	// clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// close pulse count and hang limit
	always @(negedge ref_clk) begin
		cycles++;
		if (close_tcp_r === 1'b1) closes++;
		if (cycles == 20000) begin
			num_errors++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim

	task automatic check(input logic [23:0] got, exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// model of the map; st 0 no timeout, 1 stopped, 2 running, 3 expired
	task automatic model(input bit wr, input logic [15:0] a, d, output logic [23:0] e);
		logic [15:0] r;
		logic  [7:0] x;
		bit          am;
		r = '0;
		x = 8'h00;
		am = setup[7];
		if (!wr) case (a)
			16'hfa00: x = 8'h01;
			16'hfa01: r = tmo[15:0];
			16'hfa02: r = (st == 0) ? 16'hffff : 16'(st - 1);
			16'hfa03: r = setup[15:0];
			16'hfa04: r = guard[15:0];
			16'hfa0a: r = led1;
			16'hfa0b: r = led2;
			16'hfa0c: r = led3;
			16'hfa0d: r = ctrl_running ? 16'h0002 : 16'h0001;
			16'hfa10, 16'hfa11, 16'hfa12, 16'hfa13: r = order[16*(16'hfa13 - a) +: 16];
			16'hfa14: r = fw_st;
			16'hfa15: r = hw_rev;
			16'hfa16: r = ld_rev;
			16'hfa17: r = fsw_pkg::VAL_IMAGE_VER;
			16'hfa20, 16'hfa21, 16'hfa22: r = hw_adr[16*(16'hfa22 - a) +: 16];
			16'hfa40, 16'hfa41, 16'hfa43, 16'hfa44: r = 16'h7d00;
			16'hfa42, 16'hfa45: r = 16'h8000;
			16'hfaa0: r = 16'h1234;
			16'hfaa1: r = 16'haaaa;
			16'hfaa2: r = 16'h5555;
			default: r = '0;
		endcase
		else case (a)
			16'hfa01: if (st >= 2) x = 8'h01;
				else begin
					tmo = d;
					st = (d == 0) ? 0 : (am ? 2 : 1);
				end
			16'hfa03: if (!am && st >= 2) x = 8'h01;
				else begin
					setup = d;
					st = (tmo == 0) ? 0 : (d[7] ? 2 : 1);
				end
			16'hfa04: guard = d;
			16'hfa00: if (d == 16'h5555 && tmo != 0 && (am || st != 3)) st = 2;
				else if (d == 16'h55aa && !am && (st == 1 || st == 2)) st = 1;
				else if (d == 16'haaaa && !am && st == 3) st = 1;
				else x = 8'h03;
			default: ;
		endcase
		// auto mode: an accepted access restarts it, a state read only with setup bit 1
		if (setup[7] && st == 3 && x == 8'h00 && !setup[0] && (wr || a != 16'hfa02 || setup[1]))
			st = 2;
		e = {r, x};
	endtask : model

	task automatic acc(input bit wr, input logic [15:0] a, d);
		logic [23:0] got, exp;
		i_master.access(wr, a, d, got);
		model(wr, a, d, exp);
		check(got, exp);
		#1;
		check({22'h0, running_r, expired_r}, {22'h0, st == 2, st == 3});
	endtask : acc

	// quiet time in ms; a running watchdog expires when asked
	task automatic idle(input int ms, input bit expire);
		repeat (ms * TICK_DIV) @(posedge ref_clk);
		if (expire && st == 2) st = 3;
	endtask : idle

	initial begin
		void'($urandom(32'h9d96_7860));
		{led1, led2, led3, fw_st, hw_rev, ld_rev} = {$urandom, $urandom, $urandom};
		{order, hw_adr} = 112'({$urandom, $urandom, $urandom, $urandom});
		ctrl_running = 1'($urandom);
		arst_n = 1'b0;
		repeat (10) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		for (int a = 'hfa00; a <= 'hfaa2; a++) if (a <= 'hfa45 || a >= 'hfaa0) acc(0, 16'(a), '0);
		ctrl_running = !ctrl_running;
		acc(0, 16'hfa0d, '0);
		acc(1, 16'hfa40, 16'($urandom));
		acc(0, 16'hfa40, '0);
		foreach (cmds[i]) acc(1, 16'hfa00, cmds[i]);
		acc(1, 16'hfa04, 16'($urandom));
		acc(0, 16'hfa04, '0);
		acc(1, 16'hfa01, 16'h0005);
		acc(1, 16'hfa00, 16'h55aa);
		acc(1, 16'hfa00, 16'h5555);
		acc(1, 16'hfa01, 16'h0009);
		repeat (4) begin
			idle(3, 0);
			i_master.trigger();
			acc(0, 16'hfa02, '0);
		end
		idle(7, 1);
		foreach (cmds[i]) acc(1, 16'hfa00, cmds[i]);
		check({22'h0, closes[1:0]}, 24'h00_0000);
		acc(1, 16'hfa03, 16'h0004);
		acc(1, 16'hfa00, 16'h5555);
		idle(7, 1);
		check({22'h0, closes[1:0]}, 24'h00_0001);
		acc(1, 16'hfa00, 16'haaaa);
		acc(1, 16'hfa03, 16'h0080);
		foreach (cmds[i]) acc(1, 16'hfa00, cmds[i]);
		acc(1, 16'hfa01, 16'h0000);
		idle(7, 1);
		acc(0, 16'hfa02, '0);
		acc(1, 16'hfa00, 16'h5555);
		acc(1, 16'hfa03, 16'h0000);
		// state reads as triggers, then explicit mode ignoring other requests
		acc(1, 16'hfa03, 16'h0082);
		idle(7, 1);
		acc(0, 16'hfa02, '0);
		acc(1, 16'hfa03, 16'h0083);
		idle(7, 1);
		i_master.trigger();
		acc(0, 16'hfa04, '0);
		acc(1, 16'hfa00, 16'h5555);
		end_sim();
	end
endmodule : fsw_watchdog_test

// checker on the design's ports
bind fsw_watchdog fsw_watchdog_props i_props (.ref_clk(ref_clk), .arst_n(arst_n),
	.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.ctrl_running(ctrl_running), .ack_r(ack_r), .rdata_r(rdata_r), .exc_r(exc_r),
	.expired_r(expired_r), .close_tcp_r(close_tcp_r), .running_r(running_r));
`default_nettype wire
